// >>> hdl/cpr_readout.sv
// readout logic of a configuration memory streaming a bitstream
// How it works
// - count on clock rise while selected, enabled
// - reset pin low holds counter, floats data
// - reset pin open drain, pulled during reset
// - deselect: standby, clear counter, float data
// - serial mode drives only lane zero
// - parallel mode drives full byte per address
// - data appears on enable, updates per edge
// - cascade output feeds next select, shared bus
// - cascade low only after passing terminal count
`timescale 1ns/1ps
`include "cpr_params.svh"
module cpr_readout
    import cpr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // configuration pins, sampled as synchronous levels
    input wire cpr_ctl_t ctl_i,
    input wire cpr_mode_t mode_i,
    // preload of the stored bitstream
    input wire cpr_prog_t prog_i,
    // data pins, enable low while driving
    output cpr_bus_t bus_o,
    // open-drain reset pin, output enable low while pulling
    output logic oe_rst_out_o,
    output logic oe_rst_oe_n_o,
    // cascade enable to the next memory's select
    output logic cascade_n_o
);
    // ***********************************
    // declarations
    // ***********************************
    localparam logic [`CPR_HOLD_W-1:0] HOLD_CYC = `CPR_HOLD_W'(`CPR_RST_PULL_CYC);
    logic enable; // selected and not held in reset
    logic config_clock_r; // previous sample of the configuration clock
    logic config_clock_rise; // one-cycle pulse on a clock rise
    logic [`CPR_CNT_W-1:0] limit; // terminal count in the present mode
    cpr_state_t st_r, st_nxt; // stream state
    logic [`CPR_CNT_W-1:0] cnt_r, cnt_nxt; // address counter
    logic [`CPR_BSEL_W-1:0] bsel_r; // bit select aligned with read data
    logic [`CPR_ADDR_W-1:0] rd_addr; // byte address into storage
    logic [`CPR_BYTE_W-1:0] rd_data; // byte read from storage
    cpr_bus_t bus_r, bus_nxt; // data pin flops
    logic cascade_r, cascade_nxt; // cascade enable flop
    logic [`CPR_HOLD_W-1:0] hold_r, hold_nxt; // reset pull stretch counter
    logic rst_oe_n_r, rst_oe_n_nxt; // reset pin pull enable

    // both pins are sampled levels; the counter only moves when both agree
    assign enable = ~ctl_i.cs_n & ctl_i.oe_rst_n;
    assign config_clock_rise = ctl_i.config_clock & ~config_clock_r;
    // serial mode counts bits, parallel mode counts bytes
    assign limit = (mode_i == CPR_MODE_SERIAL) ? `CPR_LIMIT_SERIAL : `CPR_LIMIT_PARALLEL;
    assign rd_addr = (mode_i == CPR_MODE_SERIAL) ? cnt_r[`CPR_CNT_W-1:`CPR_BSEL_W]
                                                 : cnt_r[`CPR_ADDR_W-1:0];

    // ***********************************
    // storage
    // ***********************************
    cpr_mem u_mem (
        .clk_i(clk_i),
        .prog_i(prog_i),
        .rd_addr_i(rd_addr),
        .rd_data_o(rd_data)
    );

    // ***********************************
    // address counter and stream state
    // ***********************************
    // next state; the loader keeps clocking rules on its own side
    always_comb begin
        st_nxt = st_r;
        cnt_nxt = cnt_r;
        if (!enable) begin
            // deselected or reset pin low: counter back to zero
            st_nxt = CPR_ST_HOLD;
            cnt_nxt = '0;
        end else begin
            case (st_r)
                CPR_ST_HOLD, CPR_ST_STREAM: begin
                    // an edge in the enabling cycle still counts
                    st_nxt = CPR_ST_STREAM;
                    if (config_clock_rise) begin
                        if (cnt_r == limit) begin
                            // counter holds at the terminal count; the stream is spent
                            st_nxt = CPR_ST_DONE;
                        end else begin
                            cnt_nxt = cnt_r + 1'b1;
                        end
                    end
                end
                CPR_ST_DONE: begin
                    // stays spent until deselected or reset
                    st_nxt = CPR_ST_DONE;
                end
                default: begin
                    st_nxt = CPR_ST_HOLD;
                    cnt_nxt = '0;
                end
            endcase
        end
    end

    // registers of the counter group
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            st_r <= CPR_ST_HOLD;
            cnt_r <= '0;
            config_clock_r <= 1'b0;
            bsel_r <= '0;
        end else begin
            st_r <= st_nxt;
            cnt_r <= cnt_nxt;
            config_clock_r <= ctl_i.config_clock;
            bsel_r <= cnt_r[`CPR_BSEL_W-1:0];
        end
    end

    // ***********************************
    // data pins and cascade output
    // ***********************************
    // data follows the counter by two clocks, well inside a slow loader period
    always_comb begin
        bus_nxt.dout = `CPR_DOUT_IDLE;
        bus_nxt.oe_n = `CPR_OE_N_IDLE;
        cascade_nxt = 1'b1;
        if (enable && st_nxt == CPR_ST_DONE) begin
            // pass the bus on to the next memory in the chain
            cascade_nxt = 1'b0;
        end else if (enable) begin
            if (mode_i == CPR_MODE_SERIAL) begin
                // most significant bit of each byte goes first
                bus_nxt.dout[0] = rd_data[`CPR_BYTE_W-1-bsel_r];
                bus_nxt.oe_n = `CPR_OE_N_LANE0;
            end else begin
                bus_nxt.dout = rd_data;
                bus_nxt.oe_n = `CPR_OE_N_ALL;
            end
        end
    end

    // registers of the pin group
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            bus_r.dout <= `CPR_DOUT_IDLE;
            bus_r.oe_n <= `CPR_OE_N_IDLE;
            cascade_r <= 1'b1;
        end else begin
            bus_r <= bus_nxt;
            cascade_r <= cascade_nxt;
        end
    end

    // ***********************************
    // open-drain reset pin
    // ***********************************
    // stretch the pull past reset so the loader surely sees it
    always_comb begin
        hold_nxt = hold_r;
        if (hold_r != '0) begin
            hold_nxt = hold_r - 1'b1;
        end
        rst_oe_n_nxt = (hold_r == '0);
    end

    // registers of the reset pin group
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            hold_r <= HOLD_CYC;
            rst_oe_n_r <= 1'b0;
        end else begin
            hold_r <= hold_nxt;
            rst_oe_n_r <= rst_oe_n_nxt;
        end
    end

    // ***********************************
    // outputs
    // ***********************************
    assign bus_o = bus_r;
    assign cascade_n_o = cascade_r;
    assign oe_rst_out_o = 1'b0; // open drain only ever pulls low
    assign oe_rst_oe_n_o = rst_oe_n_r;

    // ***********************************
    // assertions
    // ***********************************
    sequence pull_seq;
        !rst_oe_n_r [*6] ##1 rst_oe_n_r;
    endsequence

    sequence advance_seq;
        enable && config_clock_rise && st_r == CPR_ST_STREAM && cnt_r != limit;
    endsequence

    count_step_a: assert property (@(posedge clk_i) disable iff (srst_i)
        advance_seq |=> cnt_r == $past(cnt_r) + 1'b1)
        else $error("counter did not step on clock rise");
    no_step_a: assert property (@(posedge clk_i) disable iff (srst_i)
        enable && !config_clock_rise && st_r != CPR_ST_HOLD |=> $stable(cnt_r))
        else $error("counter moved without clock rise");
    reset_hold_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !ctl_i.oe_rst_n |=> cnt_r == '0 && bus_r.oe_n == `CPR_OE_N_IDLE)
        else $error("reset pin low did not hold counter and float data");
    pin_pull_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $fell(srst_i) |-> pull_seq)
        else $error("reset pin pull length wrong");
    standby_a: assert property (@(posedge clk_i) disable iff (srst_i)
        ctl_i.cs_n |=> cnt_r == '0 && bus_r.oe_n == `CPR_OE_N_IDLE && cascade_r)
        else $error("deselect did not enter standby");
    serial_lanes_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $past(mode_i) == CPR_MODE_SERIAL |-> &bus_r.oe_n[`CPR_BYTE_W-1:1])
        else $error("upper lanes driven in serial mode");
    byte_lanes_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $past(mode_i) == CPR_MODE_PARALLEL && !bus_r.oe_n[0] |-> bus_r.oe_n == `CPR_OE_N_ALL)
        else $error("parallel mode not driving full byte");
    first_data_a: assert property (@(posedge clk_i) disable iff (srst_i)
        $rose(enable) ##1 enable |-> !bus_r.oe_n[0])
        else $error("data not presented after enable");
    cascade_low_a: assert property (@(posedge clk_i) disable iff (srst_i)
        enable && st_r == CPR_ST_DONE |=> !cascade_r)
        else $error("cascade not low after terminal count");
    cascade_high_a: assert property (@(posedge clk_i) disable iff (srst_i)
        !enable || st_nxt != CPR_ST_DONE |=> cascade_r)
        else $error("cascade low without terminal count");
    release_bus_a: assert property (@(posedge clk_i) disable iff (srst_i)
        st_r == CPR_ST_DONE |-> bus_r.oe_n == `CPR_OE_N_IDLE)
        else $error("data lines driven after terminal count");
endmodule : cpr_readout

// >>> hdl/cpr_params.svh
// constants of the configuration memory readout
`ifndef CPR_PARAMS_SVH
`define CPR_PARAMS_SVH
// ***********************************
// storage geometry
// ***********************************
`define CPR_BYTE_W 8
`define CPR_ADDR_W 10
`define CPR_DEPTH 1024
`define CPR_CNT_W 13
`define CPR_BSEL_W 3
// ***********************************
// terminal counts per mode
// ***********************************
`define CPR_LIMIT_SERIAL 13'h1fff
`define CPR_LIMIT_PARALLEL 13'h03ff
// ***********************************
// idle and driving values of the pins
// ***********************************
`define CPR_OE_N_IDLE 8'hff
`define CPR_OE_N_ALL 8'h00
`define CPR_OE_N_LANE0 8'hfe
`define CPR_DOUT_IDLE 8'h00
// ***********************************
// timing
// ***********************************
`define CPR_CLK_NS 10
`define CPR_RST_PULL_NS 50
`define CPR_RST_PULL_CYC ((`CPR_RST_PULL_NS + `CPR_CLK_NS - 1) / `CPR_CLK_NS)
`define CPR_HOLD_W 3
`endif

// >>> hdl/cpr_pkg.sv
// types shared by the configuration memory readout
`include "cpr_params.svh"
package cpr_pkg;
    // ***********************************
    // modes and states
    // ***********************************
    typedef enum logic {
        CPR_MODE_SERIAL = 1'b0,
        CPR_MODE_PARALLEL = 1'b1
    } cpr_mode_t;
    typedef enum logic [1:0] {
        CPR_ST_HOLD = 2'b00,
        CPR_ST_STREAM = 2'b01,
        CPR_ST_DONE = 2'b10
    } cpr_state_t;
    // ***********************************
    // pin bundles
    // ***********************************
    typedef struct packed {
        logic config_clock;
        logic cs_n;
        logic oe_rst_n;
    } cpr_ctl_t;
    typedef struct packed {
        logic [`CPR_BYTE_W-1:0] dout;
        logic [`CPR_BYTE_W-1:0] oe_n;
    } cpr_bus_t;
    typedef struct packed {
        logic we;
        logic [`CPR_ADDR_W-1:0] addr;
        logic [`CPR_BYTE_W-1:0] data;
    } cpr_prog_t;
endpackage : cpr_pkg

// >>> hdl/cpr_mem.sv
// bitstream storage array with one write and one registered read port
`timescale 1ns/1ps
`include "cpr_params.svh"
module cpr_mem
    import cpr_pkg::*;
(
    // clock
    input wire logic clk_i,
    // preload port
    input wire cpr_prog_t prog_i,
    // read port
    input wire logic [`CPR_ADDR_W-1:0] rd_addr_i,
    output logic [`CPR_BYTE_W-1:0] rd_data_o
);
    // stored bitstream, not reset so it can map onto block memory
    logic [`CPR_BYTE_W-1:0] mem_r [`CPR_DEPTH];

    // ***********************************
    // write and read
    // ***********************************
    // read data lags the address by one clock
    always_ff @(posedge clk_i) begin
        if (prog_i.we) begin
            mem_r[prog_i.addr] <= prog_i.data;
        end
        rd_data_o <= mem_r[rd_addr_i];
    end
endmodule : cpr_mem

// >>> sim/cpr_loader.sv
// loader model that clocks the readout and captures its words
`timescale 1ns/1ps
module cpr_loader
    import cpr_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic srst_i,
    // frame request and pin levels
    input wire logic go_i,
    input wire logic [31:0] pulses_i,
    input wire logic [7:0] pins_i,
    // configuration clock to the memory
    output logic config_clock_o
);
    // ***********************************
    // clock generation and capture
    // ***********************************
    logic [7:0] got [$]; // words taken this frame
    int left; // pulses still owed
    logic [1:0] div_r; // four system cycles per half period
    initial config_clock_o = 1'b0;
    // clock stands low between frames, so no stray edge reaches the memory
    always @(posedge clk_i) begin
        if (srst_i || go_i) begin
            left <= srst_i ? 0 : pulses_i;
            div_r <= 2'h0;
            config_clock_o <= 1'b0;
            if (go_i) got.delete();
        end else if (left > 0) begin
            div_r <= div_r + 2'h1;
            if (div_r == 2'h3) begin
                config_clock_o <= !config_clock_o;
                // word set up by the previous rise is taken on this rise
                if (!config_clock_o) got.push_back(pins_i);
                else left <= left - 1;
            end
        end
    end
endmodule : cpr_loader

// >>> sim/cpr_readout_test.sv
// self-checking bench of the configuration memory readout
`timescale 1ns/1ps
module cpr_readout_test
    import cpr_pkg::*;
;
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    logic cs_n = 1'b1; // select driven by the bench
    logic ext_n = 1'b1; // outside driver of the reset wire
    logic go = 1'b0;
    int pulses = 0;
    cpr_mode_t mode = CPR_MODE_PARALLEL;
    cpr_prog_t prog = '0;
    cpr_bus_t bus;
    cpr_ctl_t ctl;
    logic config_clock, rst_out, rst_oe_n, casc_n;
    logic [7:0] pins;
    int errors = 0;
    int checks_done = 0;
    always #5 clk_i = !clk_i;
    // wired-and reset line with pull-up
    assign ctl = '{config_clock: config_clock, cs_n: cs_n, oe_rst_n: ext_n & (rst_oe_n | rst_out)};
    // a released lane shows the inverse, never a lucky match
    assign pins = bus.dout ^ bus.oe_n;
    cpr_readout dut (.clk_i(clk_i), .srst_i(srst_i), .ctl_i(ctl), .mode_i(mode),
        .prog_i(prog), .bus_o(bus), .oe_rst_out_o(rst_out), .oe_rst_oe_n_o(rst_oe_n),
        .cascade_n_o(casc_n));
    cpr_loader ldr (.clk_i(clk_i), .srst_i(srst_i), .go_i(go), .pulses_i(pulses),
        .pins_i(pins), .config_clock_o(config_clock));
    // ***********************************
    // helpers
    // ***********************************
    function automatic logic [7:0] pat(input int a);
        return a[7:0] ^ 8'h5a;
    endfunction : pat
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : cyc
    // one loader frame; length fixed by the loader's clock rate
    task automatic frame(input int n);
        go <= 1'b1;
        pulses <= n;
        cyc(1);
        go <= 1'b0;
        cyc(n * 8 + 6);
    endtask : frame
    // deselect to clear the counter, then select in the given mode
    task automatic restart(input cpr_mode_t m);
        cs_n <= 1'b1;
        mode <= m;
        cyc(3);
        cs_n <= 1'b0;
        cyc(4);
    endtask : restart
    task automatic print_verdict();
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : print_verdict
    // ***********************************
    // scenarios
    // ***********************************
    task automatic t_pull();
        int low;
        low = 0;
        srst_i <= 1'b0;
        // look just after each edge, starting with the last edge that saw reset
        repeat (12) begin
            #1;
            if (rst_oe_n === 1'b0) low++;
            cyc(1);
        end
        cyc(1);
        chk(8'(low), 8'h06);
        chk({7'h0, rst_out}, 8'h00);
    endtask : t_pull
    task automatic t_load();
        for (int a = 0; a < 1024; a++) begin
            prog <= '{we: 1'b1, addr: a[9:0], data: pat(a)};
            cyc(1);
        end
        prog.we <= 1'b0;
        cyc(1);
    endtask : t_load
    task automatic t_par();
        restart(CPR_MODE_PARALLEL);
        chk(bus.oe_n, 8'h00);
        frame(20);
        chk(8'(ldr.got.size()), 8'h14);
        for (int i = 0; i < 20; i++) chk(ldr.got[i], pat(i));
        chk({7'h0, casc_n}, 8'h01);
    endtask : t_par
    task automatic t_hold();
        ext_n <= 1'b0;
        cyc(3);
        chk(bus.oe_n, 8'hff);
        frame(4);
        ext_n <= 1'b1;
        cyc(4);
        frame(3);
        for (int i = 0; i < 3; i++) chk(ldr.got[i], pat(i));
    endtask : t_hold
    task automatic t_desel();
        frame(5);
        cs_n <= 1'b1;
        cyc(3);
        chk(bus.oe_n, 8'hff);
        cs_n <= 1'b0;
        cyc(4);
        frame(2);
        chk(ldr.got[0], pat(0));
        chk(ldr.got[1], pat(1));
    endtask : t_desel
    task automatic t_ser();
        logic [7:0] e;
        restart(CPR_MODE_SERIAL);
        chk(bus.oe_n, 8'hfe);
        frame(16);
        for (int i = 0; i < 16; i++) begin
            e = pat(i / 8);
            chk({7'h0, ldr.got[i][0]}, {7'h0, e[7 - i % 8]});
        end
    endtask : t_ser
    task automatic t_last();
        restart(CPR_MODE_PARALLEL);
        frame(1023);
        chk({casc_n, bus.oe_n[6:0]}, 8'h80);
        frame(1);
        chk(ldr.got[0], pat(1023));
        chk(bus.oe_n, 8'hff);
        chk({7'h0, casc_n}, 8'h00);
        frame(2);
        chk({casc_n, bus.oe_n[6:0]}, 8'h7f);
        cs_n <= 1'b1;
        cyc(2);
        chk({7'h0, casc_n}, 8'h01);
    endtask : t_last
    // ***********************************
    // main sequence and watchdog
    // ***********************************
    initial begin
        cyc(6);
        t_pull();
        t_load();
        t_par();
        t_hold();
        t_desel();
        t_ser();
        t_last();
        print_verdict();
    end
    // whole run is near 9750 cycles; a hang stops well past that
    initial begin
        cyc(40000);
        errors++;
        print_verdict();
    end
endmodule : cpr_readout_test
